// File: dbi_framer.sv
// display beacon / peer indicator / device status message framer with link state
// assumes synchronous inputs; host holds fields stable while a message is sent
`timescale 1ns/1ps
`default_nettype none
`include "dbi_regs.svh"
// Contract
// R1 - the beacon repeats with a period of at most one second.
// R2 - the beacon period is set in sixtieths of a second.
// R3 - a peer indicator message follows every beacon.
// R4 - modulation codes are 1 to 4 and 5 to 15 are reserved.
// R5 - device type codes are 1 to 5 and 6 to 15 are reserved.
// R6 - display codes are 1 to 5 and 7, with 8 to 15 reserved.
// R7 - connection status is 1 idle, 2 connected, 3 data exchange.
// R8 - communication status is 1 packet error rate, 2 bit error rate, rest reserved.
// R9 - the device status message carries the transferred or remaining file size.
// R10 - link adaptation is carried in the beacon and peer indicator messages.
// R11 - the link state machine has exactly idle, connection and data exchange.
// R12 - in point-to-multipoint use the device status message is also sent each period.
// R13 - the receiver ignores reserved indicator codes without changing state.
module dbi_framer
  import dbi_pkg::*;
#(
  parameter int unsigned TICK_DIV = `DBI_TICK_DIV
)
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_ce,
  input  wire logic [7:0]  i_period,
  input  wire logic        i_p2mp,
  input  wire logic [3:0]  i_modulation,
  input  wire logic [3:0]  i_dev_type,
  input  wire logic [3:0]  i_disp_info,
  input  wire logic [3:0]  i_comm_status,
  input  wire logic [15:0] i_err_metric,
  input  wire logic [31:0] i_file_size,
  input  wire logic        i_connect,
  input  wire logic        i_start_data,
  input  wire logic        i_stop_data,
  input  wire logic        i_disconnect,
  input  wire logic        i_ready,
  output logic             o_valid,
  output logic [15:0]      o_data,
  output logic [3:0]       o_msg_type,
  output logic             o_last,
  output logic [1:0]       o_link_state,
  output logic             o_cfg_err
);
  typedef enum logic [1:0]
  {
    FR_WAIT   = 2'b00,
    FR_BEACON = 2'b01,
    FR_PEER   = 2'b11,
    FR_STATUS = 2'b10
  } dbi_fr_t;

  // reserved codes are replaced by zero so a peer never sees a reserved value
  function automatic logic [3:0] dbi_clean(input logic [3:0] v, input logic [3:0] lo, input logic gap);
    logic ok;
    ok = (v != 4'h0) && (v < lo) && !(gap && v == `DBI_DISP_GAP);
    return ok ? v : 4'h0;
  endfunction

  function automatic logic [7:0] dbi_clamp(input logic [7:0] p);
    logic [7:0] r;
    r = p;
    if (p == 8'h00)
      r = 8'h01;
    else if (p > `DBI_MAX_PERIOD)
      r = `DBI_MAX_PERIOD;
    return r;
  endfunction

  logic       tick;
  dbi_link_t  link;
  dbi_link_t  next_link;
  dbi_fr_t    fr;
  dbi_fr_t    next_fr;
  logic [7:0] ticks;
  logic [7:0] next_ticks;
  logic [3:0] word;
  logic [3:0] next_word;
  logic       pend;
  logic       next_pend;
  logic       next_valid;
  logic [15:0] next_data;
  logic [3:0] next_msg_type;
  logic       next_last;
  logic       next_cfg_err;
  logic [3:0] mod_c;
  logic [3:0] dev_c;
  logic [3:0] disp_c;
  logic [3:0] comm_c;
  logic [3:0] conn_c;
  logic [3:0] last_word;
  logic       fire;

  dbi_tick
  #(
    .DIV (TICK_DIV)
  )
  u_tick
  (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .o_tick    (tick)
  );

  always_comb
  begin
    mod_c  = dbi_clean(i_modulation, `DBI_MOD_RSVD_LO, 1'b0); // see R4
    dev_c  = dbi_clean(i_dev_type, `DBI_DEV_RSVD_LO, 1'b0); // see R5
    disp_c = dbi_clean(i_disp_info, `DBI_DISP_RSVD_LO, 1'b1); // see R6
    comm_c = dbi_clean(i_comm_status, `DBI_COMM_RSVD_LO, 1'b0); // see R8
    unique case (link) // see R7
      DBI_CONN: conn_c = DBI_CST_CONN;
      DBI_DATA: conn_c = DBI_CST_DATA;
      default:  conn_c = DBI_CST_IDLE;
    endcase
  end

  // link state: only three legal codes, a stray code falls back to idle
  always_comb
  begin
    next_link = link;
    unique case (link) // see R11
      DBI_IDLE: if (i_connect) next_link = DBI_CONN;
      DBI_CONN:
      begin
        if (i_disconnect)
          next_link = DBI_IDLE;
        else if (i_start_data)
          next_link = DBI_DATA;
      end
      DBI_DATA:
      begin
        if (i_disconnect)
          next_link = DBI_IDLE;
        else if (i_stop_data)
          next_link = DBI_CONN;
      end
      default: next_link = DBI_IDLE;
    endcase
  end

  // period counter; a period that ends mid-message is held until the framer is free
  always_comb
  begin
    fire       = 1'b0;
    next_ticks = ticks;
    next_pend  = pend;
    next_cfg_err = (i_period == 8'h00) || (i_period > `DBI_MAX_PERIOD);
    if (tick)
    begin
      if (ticks + 8'h01 >= dbi_clamp(i_period)) // see R1 R2
      begin
        next_ticks = 8'h00;
        next_pend  = 1'b1;
      end
      else
        next_ticks = ticks + 8'h01;
    end
    // a stalled last word must not swallow a pending period, or a beacon is lost
    if (fr == FR_WAIT && (pend || next_pend) && !(o_valid && !i_ready))
    begin
      fire      = 1'b1;
      next_pend = 1'b0;
    end
  end

  always_comb
  begin
    last_word = (fr == FR_STATUS) ? `DBI_WORDS - 4'h1 : 4'h1;
    unique case (fr)
      FR_BEACON: // see R10
        // the period in use is advertised, not the raw setting
        next_data = (word == 4'h0) ? {4'h0, 2'b00, o_link_state, mod_c, dev_c} : {8'h00, dbi_clamp(i_period)};
      FR_PEER: // see R3 R10
        next_data = (word == 4'h0) ? {dev_c, disp_c, mod_c, conn_c} : {12'h000, comm_c};
      FR_STATUS: // see R9 R12
        unique case (word)
          4'h0:    next_data = {dev_c, disp_c, conn_c, comm_c};
          4'h1:    next_data = i_err_metric;
          4'h2:    next_data = i_file_size[31:16];
          4'h3:    next_data = i_file_size[15:0];
          default: next_data = 16'h0000;
        endcase
      default: next_data = 16'h0000;
    endcase
  end

  // sequencer: beacon, then peer indicator, then device status when point-to-multipoint
  always_comb
  begin
    next_fr       = fr;
    next_word     = word;
    next_valid    = 1'b0;
    next_msg_type = o_msg_type;
    next_last     = 1'b0;
    if (o_valid && !i_ready)
    begin
      next_valid = 1'b1;
      next_last  = o_last;
    end
    else
    begin
      unique case (fr)
        FR_WAIT:
        begin
          if (fire)
          begin
            next_fr   = FR_BEACON;
            next_word = 4'h0;
          end
        end
        default:
        begin
          next_valid    = 1'b1;
          next_last     = (word == last_word);
          next_msg_type = (fr == FR_BEACON) ? `DBI_MSG_BEACON : (fr == FR_PEER) ? `DBI_MSG_PEER : `DBI_MSG_STATUS;
          next_word     = word + 4'h1;
          if (word == last_word)
          begin
            next_word = 4'h0;
            unique case (fr)
              FR_BEACON: next_fr = FR_PEER; // see R3
              FR_PEER:   next_fr = i_p2mp ? FR_STATUS : FR_WAIT; // see R12
              default:   next_fr = FR_WAIT;
            endcase
          end
        end
      endcase
    end
  end

  // output data holds while a word is stalled and loads on every other enabled cycle
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      link         <= DBI_IDLE;
      fr           <= FR_WAIT;
      ticks        <= 8'h00;
      word         <= 4'h0;
      pend         <= 1'b1;
      o_valid      <= 1'b0;
      o_data       <= 16'h0000;
      o_msg_type   <= 4'h0;
      o_last       <= 1'b0;
      o_link_state <= 2'b00;
      o_cfg_err    <= 1'b0;
    end
    else if (i_ce)
    begin
      link         <= next_link;
      fr           <= next_fr;
      ticks        <= next_ticks;
      word         <= next_word;
      pend         <= next_pend;
      o_valid      <= next_valid;
      if (!(o_valid && !i_ready))
        o_data     <= next_data;
      o_msg_type   <= next_msg_type;
      o_last       <= next_last;
      o_link_state <= next_link;
      o_cfg_err    <= next_cfg_err;
    end
  end

  int unsigned gap_cnt;
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      gap_cnt <= 0;
    else if (i_ce)
      gap_cnt <= (o_valid && o_msg_type == `DBI_MSG_BEACON) ? 0 : gap_cnt + 1;
  end

  period_bound_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R1
    gap_cnt <= 61 * TICK_DIV + 64) else $error("beacon gap exceeds one second");

  peer_follows_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R3
    (i_ce && o_valid && i_ready && o_last && o_msg_type == `DBI_MSG_BEACON) |=> (o_valid && o_msg_type == `DBI_MSG_PEER))
    else $error("peer message did not follow beacon");

  mod_code_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R4
    (o_valid && o_msg_type == `DBI_MSG_PEER && fr == FR_PEER && word == 4'h1) |-> o_data[7:4] < `DBI_MOD_RSVD_LO)
    else $error("reserved modulation code sent");

  dev_code_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R5
    dev_c < `DBI_DEV_RSVD_LO) else $error("reserved device type code");

  disp_code_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R6
    disp_c < `DBI_DISP_RSVD_LO && disp_c != `DBI_DISP_GAP) else $error("reserved display code");

  conn_map_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R7
    conn_c == ((link == DBI_IDLE) ? DBI_CST_IDLE : (link == DBI_CONN) ? DBI_CST_CONN : DBI_CST_DATA))
    else $error("connection code mismatch");

  comm_code_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R8
    comm_c < `DBI_COMM_RSVD_LO) else $error("reserved communication code");

  link_legal_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R11
    o_link_state != 2'b10) else $error("illegal link state");

  data_needs_conn_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R11
    (i_ce && $rose(o_link_state == DBI_DATA)) |-> $past(link) == DBI_CONN) else $error("data state not via connection");

  status_p2mp_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R12 R9
    (o_valid && o_msg_type == `DBI_MSG_STATUS) |-> (fr == FR_STATUS || fr == FR_WAIT)) else $error("status outside p2mp sequence");
endmodule
`default_nettype wire

// File: dbi_pkg.sv
// types for the display beacon and indicator message framer
// assumes dbi_regs.svh for the numeric constants
`default_nettype none
package dbi_pkg;
  typedef enum logic [1:0]
  {
    DBI_IDLE = 2'b00,
    DBI_CONN = 2'b01,
    DBI_DATA = 2'b11
  } dbi_link_t;
  typedef enum logic [3:0]
  {
    DBI_MOD_PSK = 4'h1,
    DBI_MOD_FSK = 4'h2,
    DBI_MOD_HYB = 4'h3,
    DBI_MOD_S2D = 4'h4
  } dbi_mod_t;
  typedef enum logic [3:0]
  {
    DBI_CST_IDLE = 4'h1,
    DBI_CST_CONN = 4'h2,
    DBI_CST_DATA = 4'h3
  } dbi_conn_t;
endpackage
`default_nettype wire

// File: dbi_regs.svh
// constants for the display beacon and indicator message framer
// assumes a 125 MHz clock; included by bare name
`ifndef DBI_REGS_SVH
`define DBI_REGS_SVH
`define DBI_CLK_HZ          125000000
`define DBI_TICK_DIV        2083333
`define DBI_MAX_PERIOD      8'd60
`define DBI_RST_PERIOD      8'd60
`define DBI_MSG_BEACON      4'h1
`define DBI_MSG_PEER        4'h2
`define DBI_MSG_STATUS      4'h3
`define DBI_MOD_RSVD_LO     4'h5
`define DBI_DEV_RSVD_LO     4'h6
`define DBI_DISP_RSVD_LO    4'h8
`define DBI_DISP_GAP        4'h6
`define DBI_CONN_RSVD_LO    4'h4
`define DBI_COMM_RSVD_LO    4'h3
`define DBI_WORDS           4'h6
`endif

// File: dbi_sink.sv
// receiver model: accepts framer words and records each message word
// assumes the framer clock; stalls at random when asked to
`timescale 1ns/1ps
`default_nettype none
module dbi_sink
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_stall,
  input  wire logic        i_valid,
  input  wire logic [15:0] i_data,
  input  wire logic [3:0]  i_msg_type,
  input  wire logic        i_last,
  output logic             o_ready
);
  logic [20:0] words[$];
  logic        mid = 1'b0;
  logic [3:0]  peer_link = 4'h1;
  int          cyc = 0;
  int          bcn_at = 0;
  int          gap = 0;
  initial o_ready = 1'b1;
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    o_ready <= i_stall ? 1'($urandom % 2) : 1'b1;
    if (i_sys_rst)
      mid <= 1'b0;
    else if (i_valid && o_ready)
    begin
      words.push_back({i_last, i_msg_type, i_data});
      mid <= !i_last;
      if (!mid && i_msg_type == 4'h1)
      begin
        gap <= cyc - bcn_at;
        bcn_at <= cyc;
      end
      // reserved link codes leave the tracked state alone
      if (!mid && i_msg_type == 4'h2 && i_data[3:0] inside {4'h1, 4'h2, 4'h3})
        peer_link <= i_data[3:0];
    end
  end
endmodule
`default_nettype wire

// File: dbi_tick.sv
// frame tick generator: one pulse every sixtieth of a second
// assumes a 125 MHz clock and synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
`include "dbi_regs.svh"
module dbi_tick
#(
  parameter int unsigned DIV = `DBI_TICK_DIV
)
(
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_ce,
  output logic      o_tick
);
  logic [21:0] cnt;
  logic [21:0] next_cnt;
  logic        next_tick;
  always_comb
  begin
    next_cnt  = cnt + 22'h000001;
    next_tick = 1'b0;
    if (cnt >= 22'(DIV - 1))
    begin
      next_cnt  = 22'h000000;
      next_tick = 1'b1;
    end
  end
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      cnt    <= 22'h000000;
      o_tick <= 1'b0;
    end
    else if (i_ce)
    begin
      cnt    <= next_cnt;
      o_tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

// File: testbench.sv
// testbench: framer against a receiver model, every message word compared
// assumes dbi_sink as receiver; the tick divider is shortened to 20 cycles
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dbi_pkg::*;
  localparam int TD = 20;
  localparam logic [3:0] CS[9] = '{4'h2, 4'h1, 4'h4, 4'h2, 4'hA, 4'h1, 4'h2, 4'h4, 4'h8};
  localparam int         KS[9] = '{0, 1, 1, 2, 0, 1, 2, 1, 0};
  localparam logic [7:0] PS[5] = '{8'h00, 8'h01, 8'h03, 8'h3C, 8'h3D};
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, p2mp = 1'b0, stall = 1'b0;
  logic [3:0]  cmd = 4'h0, md = 4'h1, dv = 4'h1, ds = 4'h1, cm = 4'h1;
  logic [7:0]  per = 8'h01;
  logic [15:0] em = 16'h0000;
  logic [31:0] fs = 32'h00000000;
  logic        rdy, vld, lst, cerr;
  logic [15:0] dat;
  logic [3:0]  mt;
  logic [1:0]  ls;
  int          num_errors = 0, tests_run = 0, lk = 0;
  always #4 clk = ~clk;
  dbi_framer #(.TICK_DIV(TD)) dbi_framer_i (.i_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_period(per),
    .i_p2mp(p2mp), .i_modulation(md), .i_dev_type(dv), .i_disp_info(ds), .i_comm_status(cm),
    .i_err_metric(em), .i_file_size(fs), .i_connect(cmd[0]), .i_start_data(cmd[1]), .i_stop_data(cmd[2]),
    .i_disconnect(cmd[3]), .i_ready(rdy), .o_valid(vld), .o_data(dat), .o_msg_type(mt), .o_last(lst),
    .o_link_state(ls), .o_cfg_err(cerr));
  dbi_sink dbi_sink_i (.i_clk(clk), .i_sys_rst(rst), .i_stall(stall), .i_valid(vld), .i_data(dat),
    .i_msg_type(mt), .i_last(lst), .o_ready(rdy));
  function automatic logic [3:0] cd(input logic [3:0] v, input logic [3:0] lo, input logic g6);
    return (v == 4'h0 || v >= lo || (g6 && v == 4'h6)) ? 4'h0 : v;
  endfunction
  function automatic logic [7:0] pcl(input logic [7:0] p);
    return (p == 8'h00) ? 8'h01 : (p > 8'h3C) ? 8'h3C : p;
  endfunction
  function automatic logic [1:0] lsx(input int k);
    return (k == 0) ? 2'b00 : (k == 1) ? 2'b01 : 2'b11;
  endfunction
  task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
    tests_run++;
    if (exp !== got)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one message group; inputs set at the calling edge land before the #1
  task automatic grp();
    logic [20:0] e[$];
    logic [3:0]  lc;
    int          n;
    #1;
    lc = 4'(lk + 1);
    e = '{{5'h01, 6'h00, lsx(lk), cd(md, 4'h5, 1'b0), cd(dv, 4'h6, 1'b0)}, {5'h11, 8'h00, pcl(per)},
          {5'h02, cd(dv, 4'h6, 1'b0), cd(ds, 4'h8, 1'b1), cd(md, 4'h5, 1'b0), lc},
          {5'h12, 12'h000, cd(cm, 4'h3, 1'b0)}};
    if (p2mp)
    begin
      e.push_back({5'h03, cd(dv, 4'h6, 1'b0), cd(ds, 4'h8, 1'b1), lc, cd(cm, 4'h3, 1'b0)});
      e.push_back({5'h03, em});
      e.push_back({5'h03, fs[31:16]});
      e.push_back({5'h03, fs[15:0]});
      e.push_back({5'h03, 16'h0000});
      e.push_back({5'h13, 16'h0000});
    end
    for (n = 0; n < 3000 && dbi_sink_i.words.size() < e.size(); n++)
      @(posedge clk);
    chk("word count", 21'(e.size()), 21'(dbi_sink_i.words.size()));
    chk("receiver link", 21'(lc), 21'(dbi_sink_i.peer_link));
    foreach (e[i])
      if (i < dbi_sink_i.words.size())
        chk("message word", e[i], dbi_sink_i.words[i]);
    dbi_sink_i.words.delete();
  endtask
  initial
  begin
    void'($urandom(10644));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    grp();
    @(posedge clk);
    ce <= 1'b0;
    cmd <= 4'h1;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    cmd <= 4'h0;
    #1 chk("frozen link", 21'(2'b00), 21'(ls));
    $display("test reset and enable done");
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk);
      md <= 4'(i);
      dv <= 4'(i);
      ds <= 4'(15 - i);
      cm <= 4'(i);
      p2mp <= i[0];
      em <= 16'($urandom);
      fs <= $urandom;
      grp();
    end
    $display("test field codes done");
    for (int i = 0; i < 9; i++)
    begin
      @(posedge clk);
      cmd <= CS[i];
      @(posedge clk);
      cmd <= 4'h0;
      lk = KS[i];
      #1 chk("link state", 21'(lsx(lk)), 21'(ls));
      grp();
    end
    $display("test link states done");
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      per <= PS[i];
      repeat (3) @(posedge clk);
      #1 chk("period error", 21'(PS[i] == 8'h00 || PS[i] > 8'h3C), 21'(cerr));
      grp();
      grp();
      grp();
      chk("beacon gap", 21'(pcl(PS[i]) * TD), 21'(dbi_sink_i.gap));
    end
    $display("test beacon period done");
    // long period so a stretched group ends well before the next beacon
    @(posedge clk);
    stall <= 1'b1;
    per <= 8'h05;
    p2mp <= 1'b1;
    repeat (3) grp();
    $display("test receiver stall done");
    stop_test();
  end
  initial
  begin
    #300000;
    num_errors++;
    $display("watchdog expired");
    stop_test();
  end
endmodule
`default_nettype wire
